// ==== verilog/sync_id_gpio_pkg.sv ====
// Constants for the synchronous-parameter, destination-ID and general-purpose register bank.
// Summary of operation
// - A four-bit offset field gives the largest synchronous offset, 1 to 8, zero means asynchronous, codes above 8 are reserved.
// - The synchronous offset applies only in Data In and Data Out phases; every other phase runs asynchronously.
// - The synchronous period is the period count times the period of the divided SCSI clock.
// - The fastest transfer comes from an undivided clock with a period count of 4.
// - The low four bits of the destination ID register hold the binary target or initiator ID.
// - A Select or Reselect instruction loads the destination ID register with its encoded ID.
// - IDs rank from 7 down to 0 and then from 15 down to 8, which is the lowest.
// - Reads of the five general-purpose bits return the live pin levels, unlatched.
// - Each general-purpose bit takes its direction from the matching bit of a control register.
// - After reset general-purpose bits 3 to 0 are inputs and bit 4 is an output.
// - The send rate is the SCSI clock over the conversion factor over the period count.
// - The receive rate is the SCSI clock over the conversion factor over a fixed 4.
// - Period codes 0 to 7 select period counts 4 to 11 of divided-clock cycles.
package sync_id_gpio_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_CTL3 = 8'h03;
   localparam logic [7:0] IDX_XFER = 8'h05;
   localparam logic [7:0] IDX_DEST = 8'h06;
   localparam logic [7:0] IDX_GPIO = 8'h07;
   localparam logic [7:0] IDX_GPCTL = 8'h47;
   // Field positions.
   localparam int SCF_LSB = 4;
   localparam int PERIOD_LSB = 5;
   localparam int OFFSET_LSB = 0;
   // Reset values.
   localparam logic [7:0] CTL3_RESET = 8'h00;
   localparam logic [7:0] XFER_RESET = 8'h00;
   localparam logic [3:0] DEST_RESET = 4'h0;
   localparam logic [4:0] GPIO_OUT_RESET = 5'h00;
   // Direction bit set means input.
   localparam logic [4:0] GPDIR_RESET = 5'h0f;
   // Counts.
   localparam logic [3:0] PERIOD_BASE = 4'h4;
   localparam logic [1:0] RECV_DIV_LAST = 2'h3;
   localparam logic [3:0] MAX_OFFSET = 4'h8;
   localparam logic [3:0] HALF_STEP = 4'h2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ==== verilog/sync_id_gpio_regs.sv ====
// Register bank with synchronous pacing, destination ID and general-purpose pins.
`timescale 1ns/100ps
module sync_id_gpio_regs #(
   parameter int GP_W = 5
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [2:0] scsi_phase,
   input wire logic xfer_active,
   input wire logic sync_ack_in,
   input wire logic script_id_load,
   input wire logic [3:0] script_id,
   input wire logic [GP_W-1:0] gp_in,
   output logic [GP_W-1:0] gp_out,
   output logic [GP_W-1:0] gp_oe,
   output logic sync_mode,
   output logic sync_req,
   output logic recv_strobe,
   output logic offset_reserved,
   output logic [3:0] dest_id,
   output logic [3:0] dest_priority
);
   localparam int SEND_GAP = 3;

   logic hreadyout_q;
   logic [31:0] hrdata_q;
   logic wr_pend_q;
   logic [7:0] wr_idx_q;
   logic [7:0] ctl3_q;
   logic [7:0] xfer_q;
   logic [3:0] dest_q;
   logic [3:0] dest_d;
   logic [3:0] prio_q;
   logic [GP_W-1:0] gp_out_q;
   logic [GP_W-1:0] gp_dir_q;
   logic [GP_W-1:0] gp_oe_q;
   logic [4:0] acc_q;
   logic [3:0] per_cnt_q;
   logic [1:0] rcv_cnt_q;
   logic [3:0] outst_q;
   logic sync_mode_q;
   logic sync_req_q;
   logic recv_q;
   logic resv_q;
   logic addr_ok;
   logic tick;
   logic send_tick;
   logic [4:0] half_f;
   logic [3:0] transfer_period_count;
   logic [3:0] max_off;
   logic data_phase;
   logic wr_hit;

   // Destination priority: 7 highest ... 0, then 15 ... 8 lowest.
   function automatic logic [3:0] id_rank(input logic [3:0] id);
      id_rank = id ^ 4'h8;
   endfunction

   // Divider in half cycles so that the divide-by-1.5 setting is exact on average.
   function automatic logic [4:0] scf_half(input logic [2:0] code);
      unique case (code)
         3'h0: scf_half = 5'h06;
         3'h1: scf_half = 5'h02;
         3'h2: scf_half = 5'h03;
         3'h3: scf_half = 5'h04;
         3'h4: scf_half = 5'h06;
         default: scf_half = 5'h08;
      endcase
   endfunction

   function automatic logic offset_is_reserved(input logic [3:0] mo);
      offset_is_reserved = mo[3] && (mo[2:0] != 3'h0);
   endfunction

   assign addr_ok = hsel && hready && htrans == sync_id_gpio_pkg::HTRANS_NONSEQ;
   assign wr_hit = wr_pend_q;
   assign half_f = scf_half(ctl3_q[sync_id_gpio_pkg::SCF_LSB +: 3]);
   assign transfer_period_count = sync_id_gpio_pkg::PERIOD_BASE
                  + {1'b0, xfer_q[sync_id_gpio_pkg::PERIOD_LSB +: 3]};
   assign max_off = xfer_q[sync_id_gpio_pkg::OFFSET_LSB +: 4];
   assign data_phase = xfer_active && scsi_phase[2:1] == 2'b00;
   assign tick = ({1'b0, acc_q} + 6'(sync_id_gpio_pkg::HALF_STEP)) >= {1'b0, half_f};
   assign send_tick = tick && ({1'b0, per_cnt_q} + 5'h01 == {1'b0, transfer_period_count});

   // AHB-Lite slave: zero wait states, always OKAY.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
      end else if (ce) begin
         hreadyout_q <= 1'b1;
         wr_pend_q <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_idx_q <= haddr[9:2];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (ce) begin
         hrdata_q <= 32'h0000_0000;
         if (addr_ok && !hwrite && haddr[31:10] == 22'h0) begin
            unique case (haddr[9:2])
               sync_id_gpio_pkg::IDX_CTL3: hrdata_q <= {24'h0, ctl3_q};
               sync_id_gpio_pkg::IDX_XFER: hrdata_q <= {24'h0, xfer_q};
               sync_id_gpio_pkg::IDX_DEST: hrdata_q <= {28'h0, dest_q};
               sync_id_gpio_pkg::IDX_GPIO: hrdata_q <= {{(32-GP_W){1'b0}}, gp_in};
               sync_id_gpio_pkg::IDX_GPCTL: hrdata_q <= {{(32-GP_W){1'b0}}, gp_dir_q};
               default: hrdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl3_q <= sync_id_gpio_pkg::CTL3_RESET;
         xfer_q <= sync_id_gpio_pkg::XFER_RESET;
      end else if (ce && wr_hit) begin
         if (wr_idx_q == sync_id_gpio_pkg::IDX_CTL3) begin
            ctl3_q <= hwdata[7:0];
         end
         if (wr_idx_q == sync_id_gpio_pkg::IDX_XFER) begin
            xfer_q <= {hwdata[7:5], 1'b0, hwdata[3:0]};
         end
      end
   end

   // instruction load wins over a bus write in the same cycle
   always_comb begin
      dest_d = dest_q;
      if (script_id_load) begin
         dest_d = script_id;
      end else if (wr_hit && wr_idx_q == sync_id_gpio_pkg::IDX_DEST) begin
         dest_d = hwdata[3:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dest_q <= sync_id_gpio_pkg::DEST_RESET;
         prio_q <= id_rank(sync_id_gpio_pkg::DEST_RESET);
      end else if (ce) begin
         dest_q <= dest_d;
         prio_q <= id_rank(dest_d);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gp_out_q <= sync_id_gpio_pkg::GPIO_OUT_RESET;
         gp_dir_q <= sync_id_gpio_pkg::GPDIR_RESET;
         gp_oe_q <= ~sync_id_gpio_pkg::GPDIR_RESET;
      end else if (ce) begin
         if (wr_hit && wr_idx_q == sync_id_gpio_pkg::IDX_GPIO) begin
            gp_out_q <= hwdata[GP_W-1:0];
         end
         if (wr_hit && wr_idx_q == sync_id_gpio_pkg::IDX_GPCTL) begin
            gp_dir_q <= hwdata[GP_W-1:0];
         end
         if (wr_hit && wr_idx_q == sync_id_gpio_pkg::IDX_GPCTL) begin
            gp_oe_q <= ~hwdata[GP_W-1:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_q <= 5'h00;
      end else if (ce) begin
         if (tick) begin
            acc_q <= 5'(acc_q + 5'(sync_id_gpio_pkg::HALF_STEP) - half_f);
         end else begin
            acc_q <= 5'(acc_q + 5'(sync_id_gpio_pkg::HALF_STEP));
         end
      end
   end

   // undivided with count 4 gives one send every four cycles
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         per_cnt_q <= 4'h0;
         rcv_cnt_q <= 2'h0;
         recv_q <= 1'b0;
      end else if (ce) begin
         if (send_tick || per_cnt_q >= transfer_period_count) begin
            per_cnt_q <= 4'h0;
         end else if (tick) begin
            per_cnt_q <= 4'(per_cnt_q + 4'h1);
         end
         if (tick) begin
            rcv_cnt_q <= 2'(rcv_cnt_q + 2'h1);
         end
         recv_q <= sync_mode_q && tick && rcv_cnt_q == sync_id_gpio_pkg::RECV_DIV_LAST;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_mode_q <= 1'b0;
         sync_req_q <= 1'b0;
         outst_q <= 4'h0;
         resv_q <= 1'b0;
      end else if (ce) begin
         resv_q <= offset_is_reserved(max_off);
         // Reserved codes fall back to asynchronous so a bad setting cannot overrun a target.
         sync_mode_q <= data_phase && max_off != 4'h0 && !offset_is_reserved(max_off);
         sync_req_q <= sync_mode_q && send_tick && outst_q < max_off
                       && !(sync_req_q && !sync_ack_in);
         if (!sync_mode_q) begin
            outst_q <= 4'h0;
         end else if (sync_req_q && !sync_ack_in) begin
            outst_q <= 4'(outst_q + 4'h1);
         end else if (!sync_req_q && sync_ack_in && outst_q != 4'h0) begin
            outst_q <= 4'(outst_q - 4'h1);
         end
      end
   end

   assign hreadyout = hreadyout_q;
   assign hrdata = hrdata_q;
   assign hresp = 1'b0;
   assign gp_out = gp_out_q;
   assign gp_oe = gp_oe_q;
   assign sync_mode = sync_mode_q;
   assign sync_req = sync_req_q;
   assign recv_strobe = recv_q;
   assign offset_reserved = resv_q;
   assign dest_id = dest_q;
   assign dest_priority = prio_q;

   sequence s_load;
      ce && script_id_load;
   endsequence

   property p_async_other_phase;
      @(posedge hclk) disable iff (!hresetn) ce && !data_phase |=> !sync_mode;
   endproperty
   a_async_other_phase: assert property (p_async_other_phase)
      else $error("sync mode outside a data phase");

   property p_send_gap;
      @(posedge hclk) disable iff (!hresetn) sync_req |=> !sync_req [*3];
   endproperty
   a_send_gap: assert property (p_send_gap)
      else $error("send requests closer than four cycles");

   property p_recv_gap;
      @(posedge hclk) disable iff (!hresetn) recv_strobe |=> !recv_strobe [*3];
   endproperty
   a_recv_gap: assert property (p_recv_gap)
      else $error("receive strobes closer than four cycles");

   property p_script_load;
      @(posedge hclk) disable iff (!hresetn)
         s_load |=> dest_id == $past(script_id) ##1 (!ce || dest_priority == (dest_id ^ 4'h8));
   endproperty
   a_script_load: assert property (p_script_load)
      else $error("destination ID not loaded from instruction");

   // Written out apart from id_rank so that a wrong ranking function is caught.
   property p_priority;
      @(posedge hclk) disable iff (!hresetn)
         dest_priority == (dest_id[3] ? {1'b0, dest_id[2:0]} : {1'b1, dest_id[2:0]});
   endproperty
   a_priority: assert property (p_priority)
      else $error("priority rank does not match destination ID");

   property p_direction;
      @(posedge hclk) disable iff (!hresetn)
         ce && wr_hit && wr_idx_q == sync_id_gpio_pkg::IDX_GPCTL
         |=> gp_oe == ~$past(hwdata[GP_W-1:0]) && gp_dir_q == $past(hwdata[GP_W-1:0]);
   endproperty
   a_direction: assert property (p_direction)
      else $error("pin enable does not follow direction bits");

   property p_live_read;
      @(posedge hclk) disable iff (!hresetn)
         ce && addr_ok && !hwrite && haddr == 32'(sync_id_gpio_pkg::IDX_GPIO) * 4
         |=> hrdata[GP_W-1:0] == $past(gp_in);
   endproperty
   a_live_read: assert property (p_live_read)
      else $error("general-purpose read not the pin level");

   property p_offset_limit;
      @(posedge hclk) disable iff (!hresetn)
         sync_mode |-> outst_q <= sync_id_gpio_pkg::MAX_OFFSET;
   endproperty
   a_offset_limit: assert property (p_offset_limit)
      else $error("outstanding offset above eight");

   property p_reserved_async;
      @(posedge hclk) disable iff (!hresetn)
         offset_reserved && ce ##1 offset_reserved |-> !sync_mode;
   endproperty
   a_reserved_async: assert property (p_reserved_async)
      else $error("reserved offset code allowed synchronous mode");

   property p_fast_period;
      @(posedge hclk) disable iff (!hresetn)
         ce && half_f == 5'h02 && tick ##1 ce && half_f == 5'h02 |-> tick;
   endproperty
   a_fast_period: assert property (p_fast_period)
      else $error("undivided clock missed a tick");
endmodule

// ==== verification/scsi_far_end.sv ====
// Far-side model: answers synchronous requests and drives the general-purpose pads.
`timescale 1ns/100ps
module scsi_far_end (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sync_req,
   input wire logic ack_stall,
   input wire logic [4:0] gp_out,
   input wire logic [4:0] gp_oe,
   input wire logic [4:0] strap,
   input wire logic strap_en,
   output logic sync_ack_in,
   output logic [4:0] gp_in
);
   int pend;
   // An acknowledge is owed for every request; a stall holds them back, never drops them.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend <= 0;
         sync_ack_in <= 1'b0;
      end else begin
         sync_ack_in <= !ack_stall && (pend + int'(sync_req)) > 0;
         pend <= pend + int'(sync_req) - int'(!ack_stall && (pend + int'(sync_req)) > 0);
      end
   end
   // Released pads take the strap value while strap_en is set, else fall to their pull-ups.
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         gp_in[i] = gp_oe[i] ? gp_out[i] : (strap_en ? strap[i] : 1'b1);
      end
   end
endmodule

// ==== verification/scsi_sync_param_id_gpio_regs_tb_top.sv ====
// Testbench for the synchronous-parameter, destination-ID and general-purpose register bank.
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("Error %0t: got %h expected %h", $time, (a), (b)); end end
module scsi_sync_param_id_gpio_regs_tb_top;
   logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2, scsi_phase = 3'h7;
   logic xfer_active = 1'b0, sync_ack_in, script_id_load = 1'b0, hreadyout, hresp;
   logic [3:0] script_id = 4'h0, dest_id, dest_priority;
   logic [4:0] gp_in, gp_out, gp_oe, strap = 5'h0a;
   logic sync_mode, sync_req, recv_strobe, offset_reserved, ack_stall = 1'b0, strap_en = 1'b1;
   int error_cnt = 0, cmp_count = 0;
   initial forever #2 hclk = ~hclk;
   sync_id_gpio_regs u_sync_id_gpio_regs (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .scsi_phase(scsi_phase), .xfer_active(xfer_active), .sync_ack_in(sync_ack_in),
      .script_id_load(script_id_load), .script_id(script_id), .gp_in(gp_in), .gp_out(gp_out),
      .gp_oe(gp_oe), .sync_mode(sync_mode), .sync_req(sync_req), .recv_strobe(recv_strobe),
      .offset_reserved(offset_reserved), .dest_id(dest_id), .dest_priority(dest_priority));
   scsi_far_end u_scsi_far_end (.hclk(hclk), .hresetn(hresetn), .sync_req(sync_req),
      .ack_stall(ack_stall), .gp_out(gp_out), .gp_oe(gp_oe), .strap(strap),
      .strap_en(strap_en), .sync_ack_in(sync_ack_in), .gp_in(gp_in));
   task automatic final_report();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // One single-word AHB transfer; read data is taken at the data-phase end edge.
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      htrans <= sync_id_gpio_pkg::HTRANS_NONSEQ;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      `CHK(hresp, 1'b0)
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      xfer(1'b1, idx, wd, rd);
   endtask
   task automatic chk_rd(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      xfer(1'b0, idx, 32'h0, rd);
      `CHK(rd, exp)
   endtask
   // Programs divider and offset, then counts send requests and receive strobes.
   task automatic sync_case(input logic [31:0] c3, input logic [31:0] xf, input int n,
                            input int lo, input int hi, input int rlo, input int rhi);
      int req, rs;
      req = 0;
      rs = 0;
      wr(sync_id_gpio_pkg::IDX_CTL3, c3);
      wr(sync_id_gpio_pkg::IDX_XFER, xf);
      repeat (3) @(posedge hclk);
      repeat (n) begin
         @(posedge hclk);
         req += int'(sync_req === 1'b1);
         rs += int'(recv_strobe === 1'b1);
      end
      `CHK(sync_mode, 1'b1)
      `CHK(req >= lo && req <= hi, 1'b1)
      `CHK(rs >= rlo && rs <= rhi, 1'b1)
   endtask
   initial begin
      #80000;
      error_cnt++;
      final_report();
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk_rd(sync_id_gpio_pkg::IDX_DEST, 32'h0);
      chk_rd(sync_id_gpio_pkg::IDX_GPCTL, 32'h0f);
      `CHK(gp_oe, 5'h10)
      chk_rd(sync_id_gpio_pkg::IDX_GPIO, 32'h0a);
      strap <= 5'h05;
      @(posedge hclk);
      chk_rd(sync_id_gpio_pkg::IDX_GPIO, 32'h05);
      wr(sync_id_gpio_pkg::IDX_GPIO, 32'h10);
      chk_rd(sync_id_gpio_pkg::IDX_GPIO, 32'h15);
      wr(sync_id_gpio_pkg::IDX_GPCTL, 32'h00);
      wr(sync_id_gpio_pkg::IDX_GPIO, 32'h0a);
      `CHK(gp_oe, 5'h1f)
      chk_rd(sync_id_gpio_pkg::IDX_GPIO, 32'h0a);
      wr(sync_id_gpio_pkg::IDX_GPCTL, 32'h1f);
      strap_en <= 1'b0;
      @(posedge hclk);
      chk_rd(sync_id_gpio_pkg::IDX_GPIO, 32'h1f);
      // Binary-encoded IDs only, as software must write them.
      wr(sync_id_gpio_pkg::IDX_DEST, 32'hf7);
      chk_rd(sync_id_gpio_pkg::IDX_DEST, 32'h07);
      `CHK(dest_priority, 4'hf)
      wr(sync_id_gpio_pkg::IDX_DEST, 32'h08);
      // The write lands at the edge on which the task returns.
      @(posedge hclk);
      `CHK(dest_priority, 4'h0)
      `CHK(dest_id, 4'h8)
      script_id <= 4'hc;
      script_id_load <= 1'b1;
      @(posedge hclk);
      script_id_load <= 1'b0;
      @(posedge hclk);
      chk_rd(sync_id_gpio_pkg::IDX_DEST, 32'h0c);
      ce <= 1'b0;
      wr(sync_id_gpio_pkg::IDX_DEST, 32'h03);
      ce <= 1'b1;
      chk_rd(sync_id_gpio_pkg::IDX_DEST, 32'h0c);
      chk_rd(8'h40, 32'h0);
      scsi_phase <= 3'h0;
      xfer_active <= 1'b1;
      ack_stall <= 1'b1;
      sync_case(32'h10, 32'h02, 40, 1, 2, 9, 11);
      ack_stall <= 1'b0;
      sync_case(32'h10, 32'h08, 40, 8, 11, 9, 11);
      sync_case(32'h10, 32'he8, 44, 3, 5, 10, 12);
      sync_case(32'h50, 32'h08, 80, 4, 6, 4, 6);
      sync_case(32'h20, 32'h08, 60, 9, 11, 9, 11);
      wr(sync_id_gpio_pkg::IDX_XFER, 32'h09);
      repeat (3) @(posedge hclk);
      `CHK(offset_reserved, 1'b1)
      `CHK(sync_mode, 1'b0)
      wr(sync_id_gpio_pkg::IDX_XFER, 32'h18);
      chk_rd(sync_id_gpio_pkg::IDX_XFER, 32'h08);
      scsi_phase <= 3'h4;
      repeat (3) @(posedge hclk);
      `CHK(sync_mode, 1'b0)
      wr(sync_id_gpio_pkg::IDX_XFER, 32'h00);
      scsi_phase <= 3'h0;
      repeat (3) @(posedge hclk);
      `CHK(sync_mode, 1'b0)
      final_report();
   end
endmodule
